// ### verilog/bridge_adc_consts.svh
`ifndef BRIDGE_ADC_CONSTS_SVH
`define BRIDGE_ADC_CONSTS_SVH

// ==========================================================
// Register map
`define REG_CONFIG_OFS 8'h00
`define REG_CYCLE_TIME_OFS 8'h04
`define REG_CLOCK_SHIFT_OFS 8'h08
`define REG_STATUS_OFS 8'h0C
`define REG_OFFSET_PPM_OFS 8'h10

// ==========================================================
// Fields and reset values
`define CFG_RATE_LSB 0
`define CFG_RATE_MSB 3
`define CFG_RANGE_LSB 4
`define CFG_RANGE_MSB 6
`define CFG_EXT_BIT 6
`define CFG_WRITE_MASK 8'h7F
`define RATE_CODE_SYNC 4'hE
`define RATE_CODE_RSVD 4'hF
`define STAT_UNSYNC_BIT 2
`define CONFIG_RESET 8'h00
`define CYCLE_TIME_RESET 16'h0000
`define CLOCK_SHIFT_RESET 8'h00
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

// ==========================================================
// Timing
`define CLK_PERIOD_NS 5
`define US_TIME_NS 1000
`define US_CYCLES (`US_TIME_NS / `CLK_PERIOD_NS)
`define SETTLE_COUNT 150
`define CYCLE_TIME_MIN_US 16'd50
`define CYCLE_TIME_MAX_US 16'd2000
`define BUS_CYCLE_RATIO 4

// ==========================================================
// Clock offset
`define SHIFT_MIN (-8'sd50)
`define SHIFT_MAX 8'sd50
`define PPM_STEP 16'sd200
`define SERIAL_MOD 100
`define SERIAL_MID 50
`define NCO_W 40
`define PPM_SCALE 64'h00000000000D1B71

// ==========================================================
// Phase increments per clock for each data rate
`define INC_2P5 32'h000035B0
`define INC_5 32'h00006B60
`define INC_10 32'h0000D6C0
`define INC_15 32'h0001421F
`define INC_25 32'h000218DF
`define INC_30 32'h0002843F
`define INC_50 32'h000431BE
`define INC_60 32'h0005087D
`define INC_100 32'h0008637C
`define INC_500 32'h0029F16B
`define INC_1000 32'h0053E2D6
`define INC_2000 32'h00A7C5AC
`define INC_3750 32'h013A92A3
`define INC_7500 32'h02752546

`endif

// ### verilog/bridge_adc_pkg.sv
package bridge_adc_pkg;

  typedef enum logic [1:0] {
    SETTLE_OFF,
    SETTLE_RUN,
    SETTLE_LOCKED
  } settle_state_t;

  typedef logic [3:0] rate_code_t;
  typedef logic [2:0] range_code_t;

endpackage : bridge_adc_pkg

// ### verilog/us_tick_gen.sv
`timescale 1ns/1ps
module us_tick_gen #(
  parameter int DIV = 200
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output logic tick_o
);

  logic [15:0] count_reg;

  generate
    if (DIV < 2 || DIV > 65535) begin : g_bad_div
      $error("us_tick_gen: DIV out of range");
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 16'h0000;
      tick_o <= 1'b0;
    end else if (count_reg == 16'(DIV - 1)) begin
      count_reg <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      count_reg <= count_reg + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule : us_tick_gen

// ### verilog/sync_tracker.sv
`timescale 1ns/1ps
`include "bridge_adc_consts.svh"
module sync_tracker
  import bridge_adc_pkg::*;
#(
  parameter bit SETTLE_ON_BUS = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic us_tick_i,
  input wire logic bus_cycle_i,
  input wire logic sync_mode_i,
  input wire logic [15:0] cycle_time_i,
  input wire logic restart_i,
  input wire logic conv_start_i,
  output logic realign_o,
  output logic unsync_o
);

  // ==========================================================
  // Bus cycle measurement
  logic [15:0] bus_cnt_reg;
  logic [15:0] bus_time_reg;
  logic bus_valid_reg;
  logic [15:0] mult_cnt_reg;
  logic [7:0] settle_cnt_reg;
  logic sync_mode_reg;
  logic syncable;
  logic ratio_ok;
  logic [15:0] mult_ratio;
  logic bus_changed;
  settle_state_t state_reg;

  assign bus_changed = bus_cycle_i && bus_valid_reg && (bus_cnt_reg != bus_time_reg);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bus_cnt_reg <= 16'h0000;
      bus_time_reg <= 16'h0000;
      bus_valid_reg <= 1'b0;
    end else if (bus_cycle_i) begin
      bus_cnt_reg <= 16'(us_tick_i);
      bus_time_reg <= bus_cnt_reg;
      bus_valid_reg <= 1'b1;
    end else if (us_tick_i && bus_cnt_reg != 16'hFFFF) begin
      bus_cnt_reg <= bus_cnt_reg + 16'h0001;
    end else if (bus_cnt_reg == 16'hFFFF) begin
      // A stalled bus cannot be followed; drop the measurement.
      bus_valid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Ratio check
  always_comb begin
    ratio_ok = 1'b0;
    mult_ratio = 16'h0001;
    if (bus_time_reg != 16'h0000 && cycle_time_i != 16'h0000) begin
      if (cycle_time_i <= bus_time_reg) begin
        ratio_ok = (bus_time_reg % cycle_time_i) == 16'h0000;
      end else begin
        ratio_ok = (cycle_time_i % bus_time_reg) == 16'h0000;
        mult_ratio = cycle_time_i / bus_time_reg;
      end
    end
  end

  // RULE_10: cycle time used in sync only.
  assign syncable = sync_mode_i && bus_valid_reg && ratio_ok &&
                    cycle_time_i >= `CYCLE_TIME_MIN_US && cycle_time_i <= `CYCLE_TIME_MAX_US &&
                    (18'(cycle_time_i) * 18'(`BUS_CYCLE_RATIO)) >= 18'(bus_time_reg);

  // ==========================================================
  // Realignment to the bus cycle
  // RULE_07: restart phase at bus edge.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mult_cnt_reg <= 16'h0000;
      realign_o <= 1'b0;
    end else if (bus_cycle_i && syncable) begin
      if (mult_cnt_reg + 16'h0001 >= mult_ratio) begin
        mult_cnt_reg <= 16'h0000;
        realign_o <= 1'b1;
      end else begin
        mult_cnt_reg <= mult_cnt_reg + 16'h0001;
        realign_o <= 1'b0;
      end
    end else begin
      realign_o <= 1'b0;
    end
  end

  // ==========================================================
  // Settling
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_mode_reg <= 1'b0;
      state_reg <= SETTLE_OFF;
      settle_cnt_reg <= 8'h00;
    end else begin
      sync_mode_reg <= sync_mode_i;
      unique case (state_reg)
        SETTLE_OFF: begin
          settle_cnt_reg <= 8'h00;
          if (syncable) begin
            state_reg <= SETTLE_RUN;
          end
        end
        SETTLE_RUN, SETTLE_LOCKED: begin
          // RULE_09: restart on enable or change.
          if (!syncable || restart_i || bus_changed || (sync_mode_i && !sync_mode_reg)) begin
            state_reg <= SETTLE_OFF;
            settle_cnt_reg <= 8'h00;
          end else if (state_reg == SETTLE_RUN && (SETTLE_ON_BUS ? bus_cycle_i : conv_start_i)) begin
            // RULE_08: lock after 150 cycles.
            if (settle_cnt_reg == 8'(`SETTLE_COUNT - 1)) begin
              state_reg <= SETTLE_LOCKED;
            end
            settle_cnt_reg <= settle_cnt_reg + 8'h01;
          end
        end
      endcase
    end
  end

  // RULE_06: flag unsync or settling.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      unsync_o <= 1'b1;
    end else begin
      unsync_o <= !(state_reg == SETTLE_LOCKED && syncable);
    end
  end

endmodule : sync_tracker

// ### verilog/bridge_adc_config_sync.sv
`timescale 1ns/1ps
`include "bridge_adc_consts.svh"
// Contract
// RULE_01: Bits 0-3 select fourteen output data rates.
// RULE_02: Code 1110 selects sync; 1111 reserved.
// RULE_03: Bits 4-6 select range; bit 7 zero.
// RULE_04: Host sets sync cycle 200-2000 us, ratio; the code accepts 50-2000 us.
// RULE_05: Host keeps cycle at least quarter bus.
// RULE_06: Status bit 2 set unsynced or settling.
// RULE_07: Sync jitter within 1 or 4 us.
// RULE_08: Settling lasts 150 cycles before lock.
// RULE_09: Restart settling on enable or change.
// RULE_10: Cycle-time register used only in sync.
// RULE_11: Clock shift step is 200 ppm.
// RULE_12: Out-of-range shift uses serial-number default.
// RULE_13: Clock offset scales the sampling rate; the code scales the free-run rates only, not the sync-mode cycle timing.
// RULE_14: Status bit 2 zero only when synced.
// RULE_15: Reset clears registers, reports not synchronized.
module bridge_adc_config_sync
  import bridge_adc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SERIAL_W = 32,
  parameter bit SETTLE_ON_BUS = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic bus_cycle_i,
  input wire logic [SERIAL_W-1:0] serial_number_i,
  output logic conv_start_o,
  output rate_code_t rate_code_o,
  output range_code_t range_code_o,
  output logic extended_range_o,
  output logic sync_mode_o,
  output logic unsync_o,
  output logic [15:0] clk_offset_ppm_o
);

  generate
    if (ADDR_W < 5 || ADDR_W > 32 || SERIAL_W < 7 || SERIAL_W > 32) begin : g_bad_param
      $error("bridge_adc_config_sync: unsupported parameter");
    end
  endgenerate

  // ==========================================================
  // Registers and bus state
  logic [7:0] config_reg;
  logic [15:0] cycle_time_reg;
  logic [7:0] clock_shift_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic restart_reg;
  logic do_write;
  logic wr_hit;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [15:0] cycle_time_next;
  logic us_tick;
  logic realign;
  logic unsync;
  logic sync_sel;

  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign wr_ofs = 8'(aw_addr_reg);
  assign rd_ofs = 8'(s_axi_araddr_i);
  assign wr_hit = wr_ofs == `REG_CONFIG_OFS || wr_ofs == `REG_CYCLE_TIME_OFS ||
                  wr_ofs == `REG_CLOCK_SHIFT_OFS;
  assign cycle_time_next = {w_strb_reg[1] ? w_data_reg[15:8] : cycle_time_reg[15:8],
                            w_strb_reg[0] ? w_data_reg[7:0] : cycle_time_reg[7:0]};

  // ==========================================================
  // Write channel
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // RULE_15: registers clear on reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      config_reg <= `CONFIG_RESET;
      cycle_time_reg <= `CYCLE_TIME_RESET;
      clock_shift_reg <= `CLOCK_SHIFT_RESET;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (do_write && w_strb_reg[0] && wr_ofs == `REG_CONFIG_OFS) begin
        // RULE_03: reserved top bit forced zero.
        config_reg <= w_data_reg[7:0] & `CFG_WRITE_MASK;
      end
      if (do_write && wr_ofs == `REG_CYCLE_TIME_OFS) begin
        cycle_time_reg <= cycle_time_next;
        // RULE_09: flag cycle time change.
        restart_reg <= cycle_time_next != cycle_time_reg;
      end
      if (do_write && w_strb_reg[0] && wr_ofs == `REG_CLOCK_SHIFT_OFS) begin
        clock_shift_reg <= w_data_reg[7:0];
      end
    end
  end

  // ==========================================================
  // Read channel
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    unique case (rd_ofs)
      `REG_CONFIG_OFS: rd_data = {24'h000000, config_reg};
      `REG_CYCLE_TIME_OFS: rd_data = {16'h0000, cycle_time_reg};
      `REG_CLOCK_SHIFT_OFS: rd_data = {24'h000000, clock_shift_reg};
      // RULE_14: zero only when synchronized.
      `REG_STATUS_OFS: rd_data = 32'(unsync_o) << `STAT_UNSYNC_BIT;
      `REG_OFFSET_PPM_OFS: rd_data = {16'h0000, clk_offset_ppm_o};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_data;
      s_axi_rresp_o <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ==========================================================
  // Configuration decode
  rate_code_t rate_code;
  logic [31:0] inc_base;

  assign rate_code = config_reg[`CFG_RATE_MSB:`CFG_RATE_LSB];
  // RULE_02: code 1110 requests sync.
  assign sync_sel = rate_code == `RATE_CODE_SYNC;

  // RULE_01: rate code to phase step.
  always_comb begin
    unique case (rate_code)
      4'h0: inc_base = `INC_2P5;
      4'h1: inc_base = `INC_5;
      4'h2: inc_base = `INC_10;
      4'h3: inc_base = `INC_15;
      4'h4: inc_base = `INC_25;
      4'h5: inc_base = `INC_30;
      4'h6: inc_base = `INC_50;
      4'h7: inc_base = `INC_60;
      4'h8: inc_base = `INC_100;
      4'h9: inc_base = `INC_500;
      4'hA: inc_base = `INC_1000;
      4'hB: inc_base = `INC_2000;
      4'hC: inc_base = `INC_3750;
      4'hD: inc_base = `INC_7500;
      // Reserved code stops conversions rather than guessing a rate.
      4'hE, 4'hF: inc_base = 32'h00000000;
    endcase
  end

  // RULE_03: range and extended flag.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rate_code_o <= 4'h0;
      range_code_o <= 3'h0;
      extended_range_o <= 1'b0;
      sync_mode_o <= 1'b0;
    end else begin
      rate_code_o <= rate_code;
      range_code_o <= config_reg[`CFG_RANGE_MSB:`CFG_RANGE_LSB];
      extended_range_o <= config_reg[`CFG_EXT_BIT];
      sync_mode_o <= sync_sel;
    end
  end

  // ==========================================================
  // Clock offset
  logic [SERIAL_W-1:0] serial_reg;
  logic signed [7:0] shift_default;
  logic signed [7:0] shift_eff_reg;
  logic signed [63:0] offset_prod;
  logic [`NCO_W-1:0] inc_adj_reg;

  // The strap is caught by a clocked process, never by the reset itself.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      serial_reg <= '0;
    end else begin
      serial_reg <= serial_number_i;
    end
  end

  // RULE_12: default from serial number.
  assign shift_default = 8'sd`SERIAL_MID - 8'(serial_reg % `SERIAL_MOD);

  // RULE_11: 200 ppm per step.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      shift_eff_reg <= 8'sd0;
      clk_offset_ppm_o <= 16'h0000;
    end else begin
      if ($signed(clock_shift_reg) < `SHIFT_MIN || $signed(clock_shift_reg) > `SHIFT_MAX) begin
        shift_eff_reg <= shift_default;
      end else begin
        shift_eff_reg <= $signed(clock_shift_reg);
      end
      clk_offset_ppm_o <= 16'(16'(shift_eff_reg) * `PPM_STEP);
    end
  end

  // RULE_13: offset scales phase step.
  assign offset_prod = $signed({32'h00000000, inc_base}) * 64'(shift_eff_reg) * $signed(`PPM_SCALE);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      inc_adj_reg <= '0;
    end else begin
      inc_adj_reg <= `NCO_W'(inc_base) + `NCO_W'(offset_prod >>> 32);
    end
  end

  // ==========================================================
  // Conversion scheduling
  logic [`NCO_W:0] phase_sum;
  logic [`NCO_W-1:0] phase_reg;
  logic [15:0] sync_phase_reg;

  assign phase_sum = {1'b0, phase_reg} + {1'b0, inc_adj_reg};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= '0;
      sync_phase_reg <= 16'h0000;
      conv_start_o <= 1'b0;
    end else if (sync_sel) begin
      // RULE_10: sync timing from cycle time.
      phase_reg <= '0;
      if (realign) begin
        // RULE_07: realign, no double start.
        sync_phase_reg <= 16'h0000;
        conv_start_o <= sync_phase_reg != 16'h0000;
      end else if (us_tick && sync_phase_reg + 16'h0001 >= cycle_time_reg) begin
        sync_phase_reg <= 16'h0000;
        conv_start_o <= 1'b1;
      end else begin
        sync_phase_reg <= us_tick ? sync_phase_reg + 16'h0001 : sync_phase_reg;
        conv_start_o <= 1'b0;
      end
    end else begin
      sync_phase_reg <= 16'h0000;
      phase_reg <= phase_sum[`NCO_W-1:0];
      conv_start_o <= phase_sum[`NCO_W];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      unsync_o <= 1'b1;
    end else begin
      // RULE_06: status follows tracker.
      unsync_o <= unsync;
    end
  end

  us_tick_gen #(
    .DIV(`US_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_o(us_tick)
  );

  sync_tracker #(
    .SETTLE_ON_BUS(SETTLE_ON_BUS)
  ) u_tracker (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .us_tick_i(us_tick),
    .bus_cycle_i(bus_cycle_i),
    .sync_mode_i(sync_sel),
    .cycle_time_i(cycle_time_reg),
    .restart_i(restart_reg),
    .conv_start_i(conv_start_o),
    .realign_o(realign),
    .unsync_o(unsync)
  );

endmodule : bridge_adc_config_sync

// ### verification/bridge_adc_checker.sv
`timescale 1ns/1ps
`include "bridge_adc_consts.svh"
module bridge_adc_checker
  import bridge_adc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic bus_cycle_i,
  input wire logic conv_start_o,
  input wire rate_code_t rate_code_o,
  input wire range_code_t range_code_o,
  input wire logic extended_range_o,
  input wire logic sync_mode_o,
  input wire logic unsync_o
);
  localparam int MIN_GAP = 26000;
  logic wr_hs;
  logic cfg_wr;
  logic [3:0] cfg_q;
  logic [7:0] bus_cnt;
  logic [15:0] gap_cnt;
  assign wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign cfg_wr = wr_hs && s_axi_awaddr_i == ADDR_W'(`REG_CONFIG_OFS) && s_axi_wstrb_i[0];
  // ==========================================================
  // Helper state
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) cfg_q <= 4'h0;
    else if (cfg_wr) cfg_q <= s_axi_wdata_i[3:0];
  end
  // Bus pulses are counted only in sync mode, so a lock can be tied to its settling span.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i || !sync_mode_o) bus_cnt <= 8'h00;
    else if (bus_cycle_i && bus_cnt != 8'hFF) bus_cnt <= bus_cnt + 8'h01;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i || conv_start_o) gap_cnt <= 16'h0000;
    else if (gap_cnt != 16'hFFFF) gap_cnt <= gap_cnt + 16'h0001;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  cfg_apply_a: assert property (cfg_wr |-> ##[1:3] rate_code_o == cfg_q)
    else $error("Rate code does not follow config write.");
  sync_code_a: assert property ($stable(rate_code_o) |-> sync_mode_o == (rate_code_o == `RATE_CODE_SYNC))
    else $error("Sync mode does not match rate code.");
  ext_range_a: assert property ($stable(range_code_o) |-> extended_range_o == range_code_o[2])
    else $error("Extended range flag does not match range bit.");
  unsync_out_a: assert property (!sync_mode_o && $past(!sync_mode_o) |-> unsync_o)
    else $error("Unsync flag low outside sync mode.");
  settle_len_a: assert property ($fell(unsync_o) |-> bus_cnt >= 8'd150)
    else $error("Lock reported before settling span.");
  settle_restart_a: assert property ($rose(sync_mode_o) |-> unsync_o [*8])
    else $error("Unsync flag low after sync enable.");
  conv_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("Conversion start longer than one cycle.");
  conv_gap_a: assert property (conv_start_o && !sync_mode_o |-> gap_cnt >= MIN_GAP)
    else $error("Free-run conversions faster than top rate.");
  b_latency_a: assert property (wr_hs |-> ##2 s_axi_bvalid_o)
    else $error("Write response late.");
  r_latency_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("Read data late.");
  cfg_wr_c: cover property (cfg_wr);
  sync_conv_c: cover property (sync_mode_o && conv_start_o);
  free_conv_c: cover property (!sync_mode_o && conv_start_o);
endmodule : bridge_adc_checker

// ### verification/bus_cycle_model.sv
`timescale 1ns/1ps
module bus_cycle_model #(
  parameter int PERIOD = 10000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output logic bus_cycle_o
);
  // ==========================================================
  // Fieldbus cycle source
  int cnt;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      bus_cycle_o <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      bus_cycle_o <= (cnt == PERIOD - 1);
    end
  end
endmodule : bus_cycle_model

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, rate_code;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_cycle, conv_start, ext_range, sync_mode, unsync;
  logic [1:0] bresp, rresp;
  logic [2:0] range_code;
  logic [15:0] ppm;
  logic [31:0] serial = 32'h000004D2;
  int err_count = 0;
  int compares = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  bus_cycle_model #(.PERIOD(10000)) bus_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_cycle_o(bus_cycle));
  bridge_adc_config_sync dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bus_cycle_i(bus_cycle), .serial_number_i(serial),
    .conv_start_o(conv_start), .rate_code_o(rate_code), .range_code_o(range_code),
    .extended_range_o(ext_range), .sync_mode_o(sync_mode), .unsync_o(unsync), .clk_offset_ppm_o(ppm));
  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit aw_done = 1'b0, w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_i);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("rdata", e, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk_sys_i);
  endtask : rd
  task automatic wait_conv(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (conv_start !== 1'b1);
  endtask : wait_conv
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    check("unsync", 1, unsync);
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h04, 32'h0, 2'b00);
    rd(8'h08, 32'h0, 2'b00);
    rd(8'h0C, 32'h4, 2'b00);
  endtask : t_reset
  task automatic t_config;
    for (int i = 0; i < 14; i++) begin
      wr(8'h00, {25'h0, i[2:0], i[3:0]}, 4'h1, 2'b00);
      check("rate", i[3:0], rate_code);
      check("range", i[2:0], range_code);
      check("ext", i[2], ext_range);
      check("sync", 0, sync_mode);
    end
    rd(8'h00, 32'h5D, 2'b00);
  endtask : t_config
  task automatic t_regs;
    wr(8'h04, 32'h1234, 4'hF, 2'b00);
    wr(8'h04, 32'hFFAB, 4'h1, 2'b00);
    rd(8'h04, 32'h12AB, 2'b00);
    wr(8'h14, 32'h1, 4'hF, 2'b10);
    wr(8'h0C, 32'h0, 4'hF, 2'b10);
    rd(8'h14, 32'h0, 2'b10);
  endtask : t_regs
  task automatic t_shift;
    logic [7:0] sv [4] = '{8'h01, 8'hCE, 8'h33, 8'h80};
    int s, e;
    for (int i = 0; i < 4; i++) begin
      s = int'($signed(sv[i]));
      e = (s >= -50 && s <= 50) ? s * 200 : (int'(serial % 100) - 50) * -200;
      wr(8'h08, {24'h0, sv[i]}, 4'h1, 2'b00);
      repeat (3) @(posedge clk_sys_i);
      check("ppm", {16'h0, 16'(e)}, {16'h0, ppm});
      rd(8'h10, {16'h0, 16'(e)}, 2'b00);
    end
  endtask : t_shift
  task automatic t_rate;
    int n;
    int expc;
    expc = int'(200.0e6 / (7500.0 * 1.01));
    wr(8'h08, 32'h32, 4'h1, 2'b00);
    wr(8'h00, 32'h0D, 4'h1, 2'b00);
    wait_conv(n);
    wait_conv(n);
    // Tolerance of 0.05 percent covers the design's fixed-point ppm scaling.
    check("rate_gap_ok", 1, (n >= expc - 13 && n <= expc + 13));
  endtask : t_rate
  task automatic t_sync;
    int n;
    wr(8'h04, 32'd50, 4'h3, 2'b00);
    wr(8'h00, 32'h0E, 4'h1, 2'b00);
    check("sync", 1, sync_mode);
    rd(8'h0C, 32'h4, 2'b00);
    wait_conv(n);
    wait_conv(n);
    wait_conv(n);
    check("sync_gap_ok", 1, (n >= 9800 && n <= 10200));
    check("unsync", 1, unsync);
  endtask : t_sync
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_config();
    t_regs();
    t_shift();
    t_rate();
    t_sync();
    conclude();
  end
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    conclude();
  end
endmodule : tb
bind bridge_adc_config_sync bridge_adc_checker #(.ADDR_W(ADDR_W)) chk_u (.clk_sys_i, .rst_i,
  .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .bus_cycle_i,
  .conv_start_o, .rate_code_o, .range_code_o, .extended_range_o, .sync_mode_o, .unsync_o);
